// ===== hw/ldo_regs_pkg.sv
// Constants and types for the reference supply and linear regulator bank.
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
package ldo_regs_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam int ADDR_W = 9;
  localparam logic [7:0] IDX_REF_CTRL = 8'h4A;
  localparam logic [7:0] IDX_REG1_VOLT = 8'h4C;
  localparam logic [7:0] IDX_REG1_CTRL = 8'h4D;
  localparam logic [7:0] IDX_REG2_VOLT = 8'h4F;
  localparam logic [7:0] IDX_REG2_CTRL = 8'h50;
  localparam logic [7:0] IDX_REG3_VOLT = 8'h52;
  localparam logic [7:0] IDX_REG3_CTRL = 8'h53;

  // ==========================================================
  // Field positions inside the control registers
  localparam int BIT_RUN = 0;
  localparam int BIT_STBY = 1;
  localparam int BIT_SLEEP = 2;
  localparam int BIT_LP = 3;
  localparam int BIT_SWITCH = 4;

  // ==========================================================
  // Implemented-bit masks and values after reset
  localparam logic [7:0] REF_CTRL_MASK = 8'h0F;
  localparam logic [7:0] PLAIN_CTRL_MASK = 8'h0F;
  localparam logic [7:0] SWITCH_CTRL_MASK = 8'h1F;
  localparam logic [7:0] WIDE_VOLT_MASK = 8'h1F;
  localparam logic [7:0] NARROW_VOLT_MASK = 8'h0F;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operating mode reported by the power state machine
  typedef enum logic [1:0]
  {
    MODE_RUN,
    MODE_STANDBY,
    MODE_SLEEP,
    MODE_OFF
  } power_mode_e;

endpackage : ldo_regs_pkg

// ===== hw/reg_access_if.sv
// Register access channel between the bus slave and the register bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface reg_access_if;
  import ldo_regs_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_hit;

  modport bus_side
  (
    output wr_en, wr_addr, wr_data, rd_addr,
    input wr_hit, rd_data, rd_hit
  );
  modport bank_side
  (
    input wr_en, wr_addr, wr_data, rd_addr,
    output wr_hit, rd_data, rd_hit
  );
endinterface : reg_access_if

// ===== hw/axil_reg_slave.sv
// AXI4-Lite slave turning bus transfers into single-cycle register access.
// Assumes one write and one read outstanding at most.
`timescale 1ns/1ps
module axil_reg_slave
  import ldo_regs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Bank side
  reg_access_if.bus_side acc
);
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic do_write;

  // ==========================================================
  // Write path: address and data taken in either order
  assign awready = !aw_full_reg;
  assign wready = !w_full_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid;
  // Lane 0 strobe off means the write changes nothing
  assign acc.wr_en = do_write && w_lane_reg;
  assign acc.wr_addr = aw_addr_reg;
  assign acc.wr_data = w_data_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= RESET_VALUE;
      w_lane_reg <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata[7:0];
        w_lane_reg <= wstrb[0];
      end
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= acc.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ==========================================================
  // Read path: data captured the edge the address is taken
  assign arready = !rvalid;
  assign acc.rd_addr = araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, acc.rd_data};
      rresp <= acc.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule : axil_reg_slave

// ===== hw/ldo_vref_control_regs.sv
// Control register bank for the DDR reference supply and three linear
// regulators. Assumes programmed defaults and the current power mode come
// from logic on the same clock; registers reached over AXI4-Lite.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module ldo_vref_control_regs
  import ldo_regs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ldo_regs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ldo_regs_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Programmed defaults, taken while otp_load is high
  input wire logic otp_load,
  input wire logic otp_ref_run_enable,
  input wire logic [2:0] otp_run_enable,
  input wire logic [1:0] programmed_switch_mode_default,
  input wire logic [4:0] otp_reg1_voltage_code,
  input wire logic [3:0] otp_reg2_voltage_code,
  input wire logic [4:0] otp_reg3_voltage_code,
  // Current mode from the power state machine
  input wire ldo_regs_pkg::power_mode_e power_mode,
  // Reference supply outputs
  output logic ddr_reference_supply_enable,
  output logic ref_supply_low_power,
  // Linear regulator outputs
  output logic [2:0] reg_enable,
  output logic [2:0] reg_low_power,
  output logic reg1_switch_mode,
  output logic reg3_switch_mode,
  output logic [4:0] reg1_voltage_code,
  output logic [3:0] reg2_voltage_code,
  output logic [4:0] reg3_voltage_code
);
  import ldo_regs_pkg::*;

  reg_access_if acc ();

  logic [7:0] ref_ctrl_reg;
  logic [7:0] volt_reg [3];
  logic [7:0] ctrl_reg [3];
  logic [2:0] wr_slot_hit;
  logic [2:0] wr_volt_hit;
  logic wr_ref_hit;
  logic in_run;
  logic in_standby;
  logic in_sleep;

  // ==========================================================
  // Bus slave
  axil_reg_slave u_slave
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .acc(acc.bus_side)
  );

  // ==========================================================
  // Address decode, shared by the read and write paths
  function automatic logic [7:0] index_of(input logic [ADDR_W-1:0] a);
    index_of = (a[1:0] == 2'h0) ? 8'(a[ADDR_W-1:2]) : 8'hFF;
  endfunction : index_of

  function automatic logic [7:0] volt_mask(input int n);
    volt_mask = (n == 1) ? NARROW_VOLT_MASK : WIDE_VOLT_MASK;
  endfunction : volt_mask

  function automatic logic [7:0] ctrl_mask(input int n);
    ctrl_mask = (n == 1) ? PLAIN_CTRL_MASK : SWITCH_CTRL_MASK;
  endfunction : ctrl_mask

  function automatic logic [7:0] volt_index(input int n);
    volt_index = (n == 0) ? IDX_REG1_VOLT :
                 (n == 1) ? IDX_REG2_VOLT : IDX_REG3_VOLT;
  endfunction : volt_index

  function automatic logic [7:0] ctrl_index(input int n);
    ctrl_index = (n == 0) ? IDX_REG1_CTRL :
                 (n == 1) ? IDX_REG2_CTRL : IDX_REG3_CTRL;
  endfunction : ctrl_index

  assign wr_ref_hit = index_of(acc.wr_addr) == IDX_REF_CTRL;
  assign acc.wr_hit = wr_ref_hit || (|wr_slot_hit) || (|wr_volt_hit);

  // ==========================================================
  // Reference supply control
  // programmed load, then software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_ctrl_reg <= RESET_VALUE;
    else if (otp_load)
    begin
      ref_ctrl_reg <= RESET_VALUE;
      ref_ctrl_reg[BIT_RUN] <= otp_ref_run_enable;
      ref_ctrl_reg[BIT_STBY] <= otp_ref_run_enable;
    end
    else if (acc.wr_en && wr_ref_hit)
      ref_ctrl_reg <= acc.wr_data & REF_CTRL_MASK;
  end

  // ==========================================================
  // Linear regulators: voltage and control per instance
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_reg
      assign wr_volt_hit[g] = index_of(acc.wr_addr) == volt_index(g);
      assign wr_slot_hit[g] = index_of(acc.wr_addr) == ctrl_index(g);

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          volt_reg[g] <= RESET_VALUE;
        else if (otp_load)
        begin
          if (g == 0)
            volt_reg[g] <= {3'h0, otp_reg1_voltage_code};
          else if (g == 1)
            volt_reg[g] <= {4'h0, otp_reg2_voltage_code};
          else
            volt_reg[g] <= {3'h0, otp_reg3_voltage_code};
        end
        else if (acc.wr_en && wr_volt_hit[g])
          volt_reg[g] <= acc.wr_data & volt_mask(g);
      end

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          ctrl_reg[g] <= RESET_VALUE;
        else if (otp_load)
        begin
          ctrl_reg[g] <= RESET_VALUE;
          // run enable from the programmed sequence
          ctrl_reg[g][BIT_RUN] <= otp_run_enable[g];
          ctrl_reg[g][BIT_STBY] <= otp_run_enable[g];
          if (g != 1)
            ctrl_reg[g][BIT_SWITCH] <=
              programmed_switch_mode_default[g / 2];
        end
        else if (acc.wr_en && wr_slot_hit[g])
        begin
          ctrl_reg[g] <= acc.wr_data & ctrl_mask(g);
          // a set switch bit cannot be cleared
          if (g != 1 && ctrl_reg[g][BIT_SWITCH])
            ctrl_reg[g][BIT_SWITCH] <= 1'b1;
        end
      end

      assign reg_enable[g] =
        (in_run && ctrl_reg[g][BIT_RUN]) ||
        (in_standby && ctrl_reg[g][BIT_STBY]) ||
        (in_sleep && ctrl_reg[g][BIT_SLEEP]);
      assign reg_low_power[g] =
        ctrl_reg[g][BIT_LP] && (in_standby || in_sleep);
    end
  endgenerate

  // ==========================================================
  // Mode gating and outputs
  assign in_run = power_mode == MODE_RUN;
  assign in_standby = power_mode == MODE_STANDBY;
  assign in_sleep = power_mode == MODE_SLEEP;

  // standby and sleep also need the main enable
  assign ddr_reference_supply_enable = ref_ctrl_reg[BIT_RUN] &&
    (in_run || (in_standby && ref_ctrl_reg[BIT_STBY]) ||
     (in_sleep && ref_ctrl_reg[BIT_SLEEP]));
  assign ref_supply_low_power = ref_ctrl_reg[BIT_LP];

  // switch bit drives the pass device fully on
  assign reg1_switch_mode = ctrl_reg[0][BIT_SWITCH];
  assign reg3_switch_mode = ctrl_reg[2][BIT_SWITCH];
  assign reg1_voltage_code = volt_reg[0][4:0];
  assign reg2_voltage_code = volt_reg[1][3:0];
  assign reg3_voltage_code = volt_reg[2][4:0];

  // ==========================================================
  // Read mux; stored values are already masked
  always_comb
  begin
    acc.rd_data = RESET_VALUE;
    acc.rd_hit = 1'b1;
    case (index_of(acc.rd_addr))
      IDX_REF_CTRL: acc.rd_data = ref_ctrl_reg;
      IDX_REG1_VOLT: acc.rd_data = volt_reg[0];
      IDX_REG1_CTRL: acc.rd_data = ctrl_reg[0];
      IDX_REG2_VOLT: acc.rd_data = volt_reg[1];
      IDX_REG2_CTRL: acc.rd_data = ctrl_reg[1];
      IDX_REG3_VOLT: acc.rd_data = volt_reg[2];
      IDX_REG3_CTRL: acc.rd_data = ctrl_reg[2];
      default: acc.rd_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Checks
  ref_run_on_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    in_run |-> ddr_reference_supply_enable == ref_ctrl_reg[BIT_RUN])
  else $error("reference run enable mismatch");

  ref_standby_on_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (in_standby && ddr_reference_supply_enable) |->
      (ref_ctrl_reg[BIT_RUN] && ref_ctrl_reg[BIT_STBY]))
  else $error("reference on in standby without both bits");

  ref_sleep_on_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    in_sleep |-> ddr_reference_supply_enable ==
      (ref_ctrl_reg[BIT_RUN] && ref_ctrl_reg[BIT_SLEEP]))
  else $error("reference sleep enable mismatch");

  ref_low_power_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (acc.wr_en && wr_ref_hit && !otp_load) |=>
      ref_supply_low_power == $past(acc.wr_data[BIT_LP]))
  else $error("reference low power not written");

  wide_code_load_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    otp_load |=> (reg1_voltage_code == $past(otp_reg1_voltage_code)
      && volt_reg[2][7:5] == 3'h0))
  else $error("wide voltage code not loaded");

  narrow_code_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (acc.wr_en && wr_volt_hit[1] && !otp_load) |=>
      volt_reg[1] == {4'h0, $past(acc.wr_data[3:0])})
  else $error("narrow voltage code wrong");

  run_clear_off_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (acc.wr_en && wr_slot_hit[1] && !acc.wr_data[BIT_RUN]
      && !otp_load) ##1 in_run |-> !reg_enable[1])
  else $error("cleared regulator still on in run");

  standby_default_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    otp_load |=> ctrl_reg[0][BIT_STBY] == ctrl_reg[0][BIT_RUN])
  else $error("standby default differs from run");

  sleep_gate_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    in_sleep |-> reg_enable[2] == ctrl_reg[2][BIT_SLEEP])
  else $error("sleep enable mismatch");

  low_power_mode_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    reg_low_power[0] |-> (!in_run && ctrl_reg[0][BIT_LP]))
  else $error("low power outside standby or sleep");

  switch_sticky_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (reg3_switch_mode && !otp_load) |=> reg3_switch_mode)
  else $error("switch mode cleared by software");

  switch_out_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (acc.wr_en && wr_slot_hit[0] && acc.wr_data[BIT_SWITCH] && !otp_load)
      |=> reg1_switch_mode)
  else $error("switch output not set by its bit");

  unused_zero_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ((ref_ctrl_reg & ~REF_CTRL_MASK) == 8'h00) &&
    ((ctrl_reg[1] & ~PLAIN_CTRL_MASK) == 8'h00))
  else $error("unused bits set");

  ref_default_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    otp_load |=> ref_ctrl_reg[BIT_RUN] == $past(otp_ref_run_enable))
  else $error("reference run default not loaded");

  narrow_code_load_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    otp_load |=> reg2_voltage_code == $past(otp_reg2_voltage_code))
  else $error("narrow voltage code not loaded");

  run_default_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    otp_load |=> ctrl_reg[2][BIT_RUN] == $past(otp_run_enable[2]))
  else $error("run enable default not loaded");

  reg1_sticky_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (reg1_switch_mode && !otp_load) |=> reg1_switch_mode)
  else $error("regulator one switch mode cleared");

  switch_set_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (acc.wr_en && wr_slot_hit[2] && acc.wr_data[BIT_SWITCH] && !otp_load)
      |=> reg3_switch_mode)
  else $error("switch mode not settable");

endmodule : ldo_vref_control_regs

// ===== bench/ldo_vref_control_regs_bench.sv
// Self-checking bench for the reference supply and regulator bank.
// Assumes the bank answers on AXI4-Lite with byte address = index * 4.
`timescale 1ns/1ps
module ldo_vref_control_regs_bench
  import ldo_regs_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, otp_load, otp_ref_run_enable;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, programmed_switch_mode_default;
  logic [2:0] otp_run_enable, reg_enable, reg_low_power;
  logic [4:0] otp_reg1_voltage_code, otp_reg3_voltage_code;
  logic [4:0] reg1_voltage_code, reg3_voltage_code;
  logic [3:0] otp_reg2_voltage_code, reg2_voltage_code;
  power_mode_e power_mode;
  logic ddr_reference_supply_enable, ref_supply_low_power;
  logic reg1_switch_mode, reg3_switch_mode;
  int fail_count = 0;
  int checked = 0;
  logic [3:0] lane_sel = 4'hF;
  localparam logic [7:0] IDXS [7] = '{IDX_REF_CTRL, IDX_REG1_VOLT,
    IDX_REG1_CTRL, IDX_REG2_VOLT, IDX_REG2_CTRL, IDX_REG3_VOLT,
    IDX_REG3_CTRL};
  localparam logic [7:0] MASKS [7] = '{8'h0F, 8'h1F, 8'h1F, 8'h0F,
    8'h0F, 8'h1F, 8'h1F};
  localparam logic [7:0] CVALS [6] = '{8'h01, 8'h03, 8'h05, 8'h06,
    8'h0A, 8'h0F};

  ldo_vref_control_regs u_ldo_vref_control_regs (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .otp_load(otp_load), .otp_ref_run_enable(otp_ref_run_enable),
    .otp_run_enable(otp_run_enable),
    .programmed_switch_mode_default(programmed_switch_mode_default),
    .otp_reg1_voltage_code(otp_reg1_voltage_code),
    .otp_reg2_voltage_code(otp_reg2_voltage_code),
    .otp_reg3_voltage_code(otp_reg3_voltage_code),
    .power_mode(power_mode),
    .ddr_reference_supply_enable(ddr_reference_supply_enable),
    .ref_supply_low_power(ref_supply_low_power),
    .reg_enable(reg_enable), .reg_low_power(reg_low_power),
    .reg1_switch_mode(reg1_switch_mode),
    .reg3_switch_mode(reg3_switch_mode),
    .reg1_voltage_code(reg1_voltage_code),
    .reg2_voltage_code(reg2_voltage_code),
    .reg3_voltage_code(reg3_voltage_code));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ==========================================================
  // Reporting and bus tasks
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Master holds each channel until its own ready is sampled high
  task automatic axi_write(input logic [ADDR_W-1:0] a,
                           input logic [31:0] d, output logic [1:0] r);
    logic aw_pend, w_pend;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= lane_sel;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    while (aw_pend || w_pend)
    begin
      @(posedge aclk);
      if (aw_pend && awready === 1'b1)
      begin
        aw_pend = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_pend && wready === 1'b1)
      begin
        w_pend = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a,
                          output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  function automatic logic [ADDR_W-1:0] baddr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : baddr

  task automatic wr_ok(input logic [7:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axi_write(baddr(idx), d, r);
    check($sformatf("bresp %h", idx), RESP_OKAY, r);
  endtask : wr_ok

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(baddr(idx), d, r);
    check($sformatf("reg %h", idx), exp, d);
    check($sformatf("rresp %h", idx), RESP_OKAY, r);
  endtask : rd_chk

  // ==========================================================
  // Expected gating per mode
  function automatic logic en(input logic [7:0] c, input power_mode_e m);
    return (m == MODE_RUN) ? c[0] : (m == MODE_STANDBY) ? c[1] :
           (m == MODE_SLEEP) ? c[2] : 1'b0;
  endfunction : en

  function automatic logic lp(input logic [7:0] c, input power_mode_e m);
    return c[3] && (m == MODE_STANDBY || m == MODE_SLEEP);
  endfunction : lp

  // ==========================================================
  // Scenarios
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic reset_values;
    for (int i = 0; i < 7; i++)
      rd_chk(IDXS[i], 32'h0);
    check("outputs", 32'h0, {reg_enable, reg1_switch_mode,
      reg3_switch_mode, reg1_voltage_code, ddr_reference_supply_enable});
  endtask : reset_values

  task automatic mode_scan(input logic [7:0] c);
    logic [7:0] c2;
    power_mode_e m;
    c2 = c ^ 8'h0F;
    wr_ok(IDX_REF_CTRL, c);
    wr_ok(IDX_REG1_CTRL, c);
    wr_ok(IDX_REG2_CTRL, c2);
    wr_ok(IDX_REG3_CTRL, c);
    for (int i = 0; i < 4; i++)
    begin
      m = power_mode_e'(i);
      @(posedge aclk);
      power_mode <= m;
      #1;
      check("ref enable", c[0] & (m == MODE_RUN | en(c, m)),
            ddr_reference_supply_enable);
      check("ref low power", c[3], ref_supply_low_power);
      check("reg enable", {en(c, m), en(c2, m), en(c, m)},
            reg_enable);
      check("reg low power", {lp(c, m), lp(c2, m), lp(c, m)},
            reg_low_power);
    end
  endtask : mode_scan

  task automatic switch_once;
    wr_ok(IDX_REG1_CTRL, 32'h10);
    wr_ok(IDX_REG1_CTRL, 32'h01);
    rd_chk(IDX_REG1_CTRL, 32'h11);
    check("switch modes", 2'b10, {reg1_switch_mode, reg3_switch_mode});
    wr_ok(IDX_REG3_CTRL, 32'h1F);
    wr_ok(IDX_REG3_CTRL, 32'h00);
    rd_chk(IDX_REG3_CTRL, 32'h10);
    check("reg3 switch", 1'b1, reg3_switch_mode);
  endtask : switch_once

  task automatic masks_and_holes;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++)
    begin
      wr_ok(IDXS[i], 32'hFFFFFFFF);
      rd_chk(IDXS[i], {24'h0, MASKS[i]});
    end
    check("codes", {5'h1F, 4'hF, 5'h1F},
          {reg1_voltage_code, reg2_voltage_code, reg3_voltage_code});
    axi_write(baddr(8'h4B), 32'hFF, r);
    check("hole bresp", RESP_SLVERR, r);
    axi_read(baddr(8'h4B), d, r);
    check("hole rresp", RESP_SLVERR, r);
    check("hole rdata", 32'h0, d);
    axi_write(baddr(IDX_REG2_VOLT) + 9'h1, 32'h00, r);
    check("misaligned bresp", RESP_SLVERR, r);
    // Lane 0 strobe off: answered, but nothing stored
    lane_sel = 4'hE;
    axi_write(baddr(IDX_REG2_VOLT), 32'h00, r);
    check("no-lane bresp", RESP_OKAY, r);
    lane_sel = 4'hF;
    rd_chk(IDX_REG2_VOLT, 32'h0F);
  endtask : masks_and_holes

  task automatic otp_defaults;
    @(posedge aclk);
    otp_ref_run_enable <= 1'b1;
    otp_run_enable <= 3'b101;
    programmed_switch_mode_default <= 2'b10;
    otp_reg1_voltage_code <= 5'h15;
    otp_reg2_voltage_code <= 4'hA;
    otp_reg3_voltage_code <= 5'h0B;
    otp_load <= 1'b1;
    @(posedge aclk);
    otp_load <= 1'b0;
    rd_chk(IDX_REF_CTRL, 32'h03);
    rd_chk(IDX_REG1_CTRL, 32'h03);
    rd_chk(IDX_REG2_CTRL, 32'h00);
    rd_chk(IDX_REG3_CTRL, 32'h13);
    rd_chk(IDX_REG1_VOLT, 32'h15);
    rd_chk(IDX_REG2_VOLT, 32'h0A);
    rd_chk(IDX_REG3_VOLT, 32'h0B);
    check("otp outputs", {2'b01, 5'h15, 4'hA, 5'h0B},
          {reg1_switch_mode, reg3_switch_mode, reg1_voltage_code,
           reg2_voltage_code, reg3_voltage_code});
  endtask : otp_defaults

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, otp_load, otp_ref_run_enable} = '0;
    {otp_run_enable, programmed_switch_mode_default} = '0;
    {otp_reg1_voltage_code, otp_reg2_voltage_code} = '0;
    otp_reg3_voltage_code = '0;
    power_mode = MODE_RUN;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    for (int i = 0; i < 6; i++)
      mode_scan(CVALS[i]);
    @(posedge aclk);
    power_mode <= MODE_RUN;
    switch_once();
    masks_and_holes();
    otp_defaults();
    do_reset();
    reset_values();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end

endmodule : ldo_vref_control_regs_bench
